//--- src/dpt_host.sv
// register front end and top of the dual-port token latch host controller
// What this block does
// - request token: write zero, read back
// - reading one means poll again
// - strobes high for recovery before token read
// - token select low, chip enable high
`timescale 1ns/100ps
module dpt_host (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // axi4-lite write address
  input wire logic [dpt_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [dpt_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory port pins
  output logic ce_n,
  output logic token_select_n,
  output logic rw_n,
  output logic oe_n,
  output logic high_lane_enable_n,
  output logic low_lane_enable_n,
  output logic [dpt_pkg::ADDR_W-1:0] port_addr,
  input wire logic [dpt_pkg::DATA_W-1:0] data_in,
  output logic [dpt_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic int_n,
  input wire logic busy_n
);
  import dpt_pkg::*;

  // register selector shared by the read and write paths
  function automatic dpt_sel_t decode(input logic [AXI_AW-1:0] a);
    case (a)
      REG_CTRL: decode = SEL_CTRL;
      REG_ADDR: decode = SEL_ADDR;
      REG_WDATA: decode = SEL_WDATA;
      REG_STATUS: decode = SEL_STATUS;
      REG_RDATA: decode = SEL_RDATA;
      default: decode = SEL_NONE;
    endcase
  endfunction

  dpt_seq_if sif ();

  ////////////////////////////////////////////////////////////////////////////
  // bus and command state
  logic aw_got, next_aw_got;
  logic w_got, next_w_got;
  logic [AXI_AW-1:0] aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q;
  logic [3:0] ws_q, next_ws_q;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  dpt_op_t op, next_op;
  logic [ADDR_W-1:0] cmd_addr, next_cmd_addr;
  logic [DATA_W-1:0] cmd_wdata, next_cmd_wdata;
  logic hi_en, next_hi_en;
  logic lo_en, next_lo_en;
  logic start, next_start;
  logic cancel, next_cancel;
  logic done_flag, next_done_flag;   // sticky, cleared by status read
  logic [31:0] status;
  logic [31:0] merged;               // incoming word merged by strobes
  logic [31:0] cur;                  // current word of the written register

  // handshake readies: one write and one read in flight at most
  assign s_axi_awready = !aw_got && !bvalid;
  assign s_axi_wready = !w_got && !bvalid;
  assign s_axi_arready = !rvalid;

  // next values for the bus slave and command registers
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_q = aw_q;
    next_w_q = w_q;
    next_ws_q = ws_q;
    next_bvalid = bvalid && !s_axi_bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !s_axi_rready;
    next_rresp = rresp;
    next_rdata = rdata;
    next_op = op;
    next_cmd_addr = cmd_addr;
    next_cmd_wdata = cmd_wdata;
    next_hi_en = hi_en;
    next_lo_en = lo_en;
    next_start = 1'b0;
    next_cancel = 1'b0;
    next_done_flag = done_flag;
    status = '0;
    status[ST_BUSY] = sif.busy;
    status[ST_DONE] = done_flag;
    status[ST_OWNED] = sif.owned;
    status[ST_INT] = sif.int_lvl;
    status[ST_PORT_BUSY] = sif.busy_lvl;
    case (decode(aw_q))
      SEL_CTRL: cur = {25'h0000000, 1'b0, lo_en, hi_en, op, 1'b0};
      SEL_ADDR: cur = {18'h00000, cmd_addr};
      SEL_WDATA: cur = {14'h0000, cmd_wdata};
      default: cur = '0;
    endcase
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = ws_q[i] ? w_q[i*8 +: 8] : cur[i*8 +: 8];
    end
    // address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_q = s_axi_wdata;
      next_ws_q = s_axi_wstrb;
    end
    if (aw_got && w_got) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (decode(aw_q))
        SEL_CTRL: begin
          next_op = dpt_op_t'(merged[CTRL_OP_MSB:CTRL_OP_LSB]);
          next_hi_en = merged[CTRL_HI];
          next_lo_en = merged[CTRL_LO];
          // a start while busy is dropped; check busy in status first
          next_start = ws_q[0] && w_q[CTRL_START] && !sif.busy;
          next_cancel = ws_q[0] && w_q[CTRL_CANCEL];
        end
        SEL_ADDR: next_cmd_addr = merged[ADDR_W-1:0];
        SEL_WDATA: next_cmd_wdata = merged[DATA_W-1:0];
        SEL_STATUS, SEL_RDATA: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_DECERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (decode(s_axi_araddr))
        SEL_CTRL: next_rdata = {25'h0000000, 1'b0, lo_en, hi_en, op, 1'b0};
        SEL_ADDR: next_rdata = {18'h00000, cmd_addr};
        SEL_WDATA: next_rdata = {14'h0000, cmd_wdata};
        SEL_STATUS: begin
          next_rdata = status;
          next_done_flag = 1'b0;
        end
        SEL_RDATA: next_rdata = {14'h0000, sif.rdata};
        default: begin
          next_rdata = '0;
          next_rresp = RESP_DECERR;
        end
      endcase
    end
    // a finish in the cycle of the status read still sets the flag
    if (sif.done) begin
      next_done_flag = 1'b1;
    end
  end

  // register bus and command state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      ws_q <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
      op <= OP_MEM_RD;
      cmd_addr <= '0;
      cmd_wdata <= '0;
      hi_en <= 1'b0;
      lo_en <= 1'b0;
      start <= 1'b0;
      cancel <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_q <= next_aw_q;
      w_q <= next_w_q;
      ws_q <= next_ws_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      op <= next_op;
      cmd_addr <= next_cmd_addr;
      cmd_wdata <= next_cmd_wdata;
      hi_en <= next_hi_en;
      lo_en <= next_lo_en;
      start <= next_start;
      cancel <= next_cancel;
      done_flag <= next_done_flag;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign sif.start = start;
  assign sif.cancel = cancel;
  assign sif.op = op;
  assign sif.addr = cmd_addr;
  assign sif.wdata = cmd_wdata;
  assign sif.hi_en = hi_en;
  assign sif.lo_en = lo_en;

  ////////////////////////////////////////////////////////////////////////////
  // pin sequencer
  dpt_seq u_seq (
    .mclk(mclk),
    .reset_n(reset_n),
    .cmd(sif.seq),
    .ce_n(ce_n),
    .token_select_n(token_select_n),
    .rw_n(rw_n),
    .oe_n(oe_n),
    .high_lane_enable_n(high_lane_enable_n),
    .low_lane_enable_n(low_lane_enable_n),
    .port_addr(port_addr),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .int_n(int_n),
    .busy_n(busy_n)
  );
endmodule

//--- src/dpt_pkg.sv
// shared constants and types for the dual-port token latch host controller
package dpt_pkg;
  // clock and pin timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int STROBE_NS = 20;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOKEN_RECOVERY_INTERVAL_NS = 15;
  localparam int RECOVERY_CYC =
    (TOKEN_RECOVERY_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_WAIT_CYC = 3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] RECOVERY_CNT = CNT_W'(RECOVERY_CYC - 1);
  localparam logic [CNT_W-1:0] SAMPLE_CNT = CNT_W'(SYNC_WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  // port widths
  localparam int ADDR_W = 14;
  localparam int DATA_W = 18;
  localparam int TOKEN_IDX_W = 3;
  // bus
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_ADDR = 8'h04;
  localparam logic [AXI_AW-1:0] REG_WDATA = 8'h08;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h0C;
  localparam logic [AXI_AW-1:0] REG_RDATA = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_OP_MSB = 3;
  localparam int CTRL_HI = 4;
  localparam int CTRL_LO = 5;
  localparam int CTRL_CANCEL = 6;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_OWNED = 2;
  localparam int ST_INT = 3;
  localparam int ST_PORT_BUSY = 4;
  // commands the controller can run on the port
  typedef enum logic [2:0] {
    OP_MEM_RD, OP_MEM_WR, OP_TOK_RD, OP_TOK_WR, OP_TOK_ACQ
  } dpt_op_t;
  // register selector
  typedef enum logic [2:0] {
    SEL_CTRL, SEL_ADDR, SEL_WDATA, SEL_STATUS, SEL_RDATA, SEL_NONE
  } dpt_sel_t;
endpackage

//--- src/dpt_seq.sv
// pin sequencer that drives one port of the dual-port memory
`timescale 1ns/100ps
module dpt_seq (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // command side
  dpt_seq_if.seq cmd,
  // port pins
  output logic ce_n,
  output logic token_select_n,
  output logic rw_n,
  output logic oe_n,
  output logic high_lane_enable_n,
  output logic low_lane_enable_n,
  output logic [dpt_pkg::ADDR_W-1:0] port_addr,
  input wire logic [dpt_pkg::DATA_W-1:0] data_in,
  output logic [dpt_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic int_n,
  input wire logic busy_n
);
  import dpt_pkg::*;

  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_SAMPLE, S_RECOVER} dpt_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage input synchronisers; stage one feeds stage two only
  logic [DATA_W+1:0] sync1, sync2, sync3;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= '1;
      sync2 <= '1;
      sync3 <= '1;
    end else begin
      sync1 <= {busy_n, int_n, data_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic stable;                // stages two and three agree
  assign stable = (sync2 == sync3);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  dpt_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic tok, next_tok;         // token access, not memory
  logic is_wr, next_is_wr;     // current access writes
  logic acq, next_acq;         // running an acquire
  logic withdraw, next_withdraw; // acquire cancelled, writing one
  logic cancel_pend, next_cancel_pend;
  logic [DATA_W-1:0] wval, next_wval;
  logic [DATA_W-1:0] rval, next_rval;
  logic owned, next_owned;
  logic done, next_done;
  logic int_lvl, next_int_lvl;
  logic busy_lvl, next_busy_lvl;
  logic [ADDR_W-1:0] addr_q, next_addr_q;
  logic hi_q, next_hi_q;
  logic lo_q, next_lo_q;
  // pin images
  logic next_ce_n, next_tsel_n, next_rw_n, next_oe_n;
  logic next_ub_n, next_lb_n, next_doe;
  logic [DATA_W-1:0] next_dout;
  logic strobe;

  // next-state logic for the access sequence
  always_comb begin
    next_state = state;
    next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - 4'h1;
    next_tok = tok;
    next_is_wr = is_wr;
    next_acq = acq;
    next_withdraw = withdraw;
    next_cancel_pend = cancel_pend | (acq & cmd.cancel);
    next_wval = wval;
    next_rval = rval;
    next_owned = owned;
    next_done = 1'b0;
    next_addr_q = addr_q;
    next_hi_q = hi_q;
    next_lo_q = lo_q;
    // pin levels only move the outer state once they agree twice
    next_int_lvl = stable ? ~sync3[DATA_W] : int_lvl;
    next_busy_lvl = stable ? ~sync3[DATA_W+1] : busy_lvl;
    case (state)
      S_IDLE: begin
        next_cancel_pend = 1'b0;
        if (cmd.start) begin
          next_state = S_SETUP;
          next_tok = (cmd.op != OP_MEM_RD) && (cmd.op != OP_MEM_WR);
          next_is_wr = (cmd.op == OP_MEM_WR) || (cmd.op == OP_TOK_WR) ||
                       (cmd.op == OP_TOK_ACQ);
          next_acq = (cmd.op == OP_TOK_ACQ);
          next_withdraw = 1'b0;
          next_addr_q = cmd.addr;
          next_hi_q = cmd.hi_en;
          next_lo_q = cmd.lo_en;
          next_wval = (cmd.op == OP_TOK_ACQ) ? '0 : cmd.wdata;
          if (cmd.op == OP_TOK_ACQ) begin
            next_owned = 1'b0;
          end
        end
      end
      S_SETUP: begin
        next_state = S_STROBE;
        next_cnt = STROBE_CNT;
      end
      S_STROBE: begin
        if (cnt == CNT_ZERO) begin
          // reads keep the strobe low until the synchronised data settles
          next_state = is_wr ? S_RECOVER : S_SAMPLE;
          next_cnt = is_wr ? RECOVERY_CNT : SAMPLE_CNT;
        end
      end
      S_SAMPLE: begin
        if (cnt == CNT_ZERO && stable) begin
          next_rval = sync3[DATA_W-1:0];
          next_state = S_RECOVER;
          next_cnt = RECOVERY_CNT;
        end
      end
      S_RECOVER: begin
        // strobes stay high for the recovery interval
        if (cnt == CNT_ZERO) begin
          if (acq && !withdraw && is_wr) begin
            // read back after the request write
            next_is_wr = 1'b0;
            next_state = S_SETUP;
          end else if (acq && !withdraw && rval[0] && !cancel_pend) begin
            // other side owns it, poll again
            next_state = S_SETUP;
          end else if (acq && !withdraw && rval[0]) begin
            // cancelled while polling: withdraw the claim with a one
            next_withdraw = 1'b1;
            next_is_wr = 1'b1;
            next_wval = {DATA_W{1'b1}};
            next_state = S_SETUP;
          end else begin
            next_owned = acq && !withdraw && !rval[0];
            next_done = 1'b1;
            next_acq = 1'b0;
            next_state = S_IDLE;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
    strobe = (next_state == S_STROBE) || (next_state == S_SAMPLE);
    // tokens use their own select with chip enable high
    next_ce_n = ~(strobe & ~next_tok);
    next_tsel_n = ~(strobe & next_tok);
    next_rw_n = ~(strobe & next_is_wr);
    next_oe_n = ~(strobe & ~next_is_wr);
    // token accesses keep both lanes off; memory uses the chosen lanes
    next_ub_n = ~(strobe & ~next_tok & next_hi_q);
    next_lb_n = ~(strobe & ~next_tok & next_lo_q);
    next_doe = next_is_wr && (next_state == S_SETUP || strobe);
    next_dout = next_wval;
  end

  // register the sequence state and the pins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      cnt <= CNT_ZERO;
      tok <= 1'b0;
      is_wr <= 1'b0;
      acq <= 1'b0;
      withdraw <= 1'b0;
      cancel_pend <= 1'b0;
      wval <= '0;
      rval <= '0;
      owned <= 1'b0;
      done <= 1'b0;
      int_lvl <= 1'b0;
      busy_lvl <= 1'b0;
      addr_q <= '0;
      hi_q <= 1'b0;
      lo_q <= 1'b0;
      ce_n <= 1'b1;
      token_select_n <= 1'b1;
      rw_n <= 1'b1;
      oe_n <= 1'b1;
      high_lane_enable_n <= 1'b1;
      low_lane_enable_n <= 1'b1;
      port_addr <= '0;
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      tok <= next_tok;
      is_wr <= next_is_wr;
      acq <= next_acq;
      withdraw <= next_withdraw;
      cancel_pend <= next_cancel_pend;
      wval <= next_wval;
      rval <= next_rval;
      owned <= next_owned;
      done <= next_done;
      int_lvl <= next_int_lvl;
      busy_lvl <= next_busy_lvl;
      addr_q <= next_addr_q;
      hi_q <= next_hi_q;
      lo_q <= next_lo_q;
      ce_n <= next_ce_n;
      token_select_n <= next_tsel_n;
      rw_n <= next_rw_n;
      oe_n <= next_oe_n;
      high_lane_enable_n <= next_ub_n;
      low_lane_enable_n <= next_lb_n;
      port_addr <= next_addr_q;
      data_out <= next_dout;
      data_oe <= next_doe;
    end
  end

  assign cmd.busy = (state != S_IDLE);
  assign cmd.done = done;
  assign cmd.owned = owned;
  assign cmd.rdata = rval;
  assign cmd.int_lvl = int_lvl;
  assign cmd.busy_lvl = busy_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the pin sequence
  sequence tok_wr_end;
    $rose(token_select_n) && $past(!rw_n);
  endsequence
  sequence tok_rd_strobe;
    !token_select_n && !oe_n && rw_n;
  endsequence

  AST_TOKEN_CE_HIGH: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !token_select_n |-> ce_n && high_lane_enable_n && low_lane_enable_n)
    else $error("token select low without chip enable high");
  AST_TOKEN_RECOVERY: assert property (
    @(posedge mclk) disable iff (!reset_n)
    tok_wr_end |-> (token_select_n && oe_n) [*3])
    else $error("token read too soon after token write");
  AST_TOKEN_REQ_ZERO: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (!token_select_n && !rw_n && acq && !withdraw) |-> data_oe && !data_out[0])
    else $error("acquire request did not write zero");
  AST_TOKEN_READ_BACK: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (tok_wr_end ##0 (acq && !withdraw)) |-> ##[3:8] tok_rd_strobe)
    else $error("acquire request not read back");
  AST_TOKEN_REPOLL: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (state == S_RECOVER && cnt == CNT_ZERO && acq && !withdraw && !is_wr &&
     rval[0] && !cancel_pend) |-> ##[2:4] tok_rd_strobe)
    else $error("lost token not polled again");
endmodule

//--- src/dpt_seq_if.sv
// command and result carrier between the register front end and sequencer
`timescale 1ns/100ps
interface dpt_seq_if;
  import dpt_pkg::*;
  logic start;                 // one-cycle command pulse
  logic cancel;                // one-cycle pulse, stops an acquire poll
  dpt_op_t op;                 // command
  logic [ADDR_W-1:0] addr;     // word address or token index
  logic [DATA_W-1:0] wdata;    // write value
  logic hi_en;                 // use high byte lane
  logic lo_en;                 // use low byte lane
  logic busy;                  // sequencer active
  logic done;                  // one-cycle pulse at command end
  logic owned;                 // last command was an acquire that won the token
  logic [DATA_W-1:0] rdata;    // last captured read value
  logic int_lvl;               // synchronised interrupt pin, high = raised
  logic busy_lvl;              // synchronised busy pin, high = busy
  modport ctl (output start, cancel, op, addr, wdata, hi_en, lo_en,
    input busy, done, owned, rdata, int_lvl, busy_lvl);
  modport seq (input start, cancel, op, addr, wdata, hi_en, lo_en,
    output busy, done, owned, rdata, int_lvl, busy_lvl);
endinterface

//--- testbench/dpt_dev_model.sv
// behavioural dual-port memory: host on one port, far side by tasks
`timescale 1ns/100ps
module dpt_dev_model (
  // pins from the host
  input wire logic mclk,
  input wire logic ce_n,
  input wire logic token_select_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic high_lane_enable_n,
  input wire logic low_lane_enable_n,
  input wire logic [13:0] port_addr,
  input wire logic [17:0] data_out,
  input wire logic data_oe,
  input wire logic busy_n,
  // pins to the host
  output logic [17:0] data_in,
  output logic int_n
);
  logic [17:0] mem [16384]; // word array
  logic [1:0] own [8]; // 0 free, 1 host, 2 far side
  logic [7:0] req [3]; // waiting requests per side
  logic [17:0] q = 18'h0; // read holding register
  logic hi, lo;
  initial begin
    int_n = 1'b1;
    foreach (mem[j]) mem[j] = 18'h0;
    foreach (own[j]) own[j] = 2'h0;
    foreach (req[j]) req[j] = 8'h0;
  end
  // token update, first caller wins a tie
  task automatic tok(input logic [1:0] s, input int i, input logic b);
    if (!b && own[i] == 2'h0) own[i] = s;
    else if (!b && own[i] != s) req[s][i] = 1'b1;
    else if (b && own[i] == s) begin
      own[i] = req[3-s][i] ? 2'(3 - s) : 2'h0;
      req[3-s][i] = 1'b0;
    end else if (b) req[s][i] = 1'b0;
  endtask
  // far side posts to the host mailbox
  task automatic far_mail();
    // scheduled like a pin change, never racing the sampling edge
    int_n <= 1'b0;
  endtask
  // writes land while the strobe is low
  // an undriven data bus writes nothing, so a missing output enable shows
  always @(posedge mclk) if (!rw_n && data_oe) begin
    if (!token_select_n && ce_n) tok(2'h1, port_addr[2:0], data_out[0]);
    else if (!ce_n && token_select_n) begin
      if (!high_lane_enable_n) mem[port_addr][17:9] = data_out[17:9];
      if (!low_lane_enable_n) mem[port_addr][8:0] = data_out[8:0];
    end
  end
  // hold value at read, own mailbox clears unless busy_n is low
  always @(negedge oe_n) begin
    #1;
    q = !token_select_n ? {18{own[port_addr[2:0]] != 2'h1}} : mem[port_addr];
    if (!ce_n && rw_n && port_addr == 14'h3FFE && busy_n) int_n = 1'b1;
  end
  // drive chosen lanes, else inverse of last
  assign hi = !oe_n && rw_n &&
    (!token_select_n || (!ce_n && !high_lane_enable_n));
  assign lo = !oe_n && rw_n &&
    (!token_select_n || (!ce_n && !low_lane_enable_n));
  assign data_in = {hi ? q[17:9] : ~q[17:9], lo ? q[8:0] : ~q[8:0]};
endmodule

//--- testbench/tb.sv
// self-checking bench for the token latch host controller
`timescale 1ns/100ps
module tb;
  import dpt_pkg::*;
  logic mclk = 0, reset_n = 0, busy_n = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, data_oe, int_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ce_n, token_select_n, rw_n, oe_n;
  logic high_lane_enable_n, low_lane_enable_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, ln;
  logic [13:0] port_addr, a;
  logic [17:0] data_in, data_out, d, m;
  int mismatches = 0, samples_checked = 0, cyc = 0, seed = 76596;
  dpt_host dpt_host_i (.*);
  dpt_dev_model dev_i (.*);
  always #2.5 mclk = ~mclk;
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // axi writes: handshakes sampled at the settled negedge
  task automatic axw(input logic [7:0] ad, input logic [31:0] dd);
    logic ta, tw, tb_;
    tb_ = 0;
    @(posedge mclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!tb_) begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb_ = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] dd);
    logic ta, got;
    got = 0;
    @(posedge mclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!got) begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      dd = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
  endtask
  task automatic go(dpt_op_t op, logic [13:0] ad, logic [17:0] dd,
                    logic [1:0] l);
    axw(REG_ADDR, {18'h0, ad});
    axw(REG_WDATA, {14'h0, dd});
    axw(REG_CTRL, {26'h0, l, op, 1'b1});
  endtask
  task automatic fin(output logic [31:0] st);
    st = 0;
    while (!st[ST_DONE]) axr(REG_STATUS, st);
  endtask
  task automatic cmd(dpt_op_t op, logic [13:0] ad, logic [17:0] dd,
                     logic [1:0] l);
    go(op, ad, dd, l);
    fin(v);
    if (op inside {OP_MEM_RD, OP_TOK_RD}) axr(REG_RDATA, v);
  endtask
  // lane merge of a write, l = {low, high}
  function automatic logic [17:0] mrg(logic [17:0] o, n, logic [1:0] l);
    return {l[0] ? n[17:9] : o[17:9], l[1] ? n[8:0] : o[8:0]};
  endfunction
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1;
    axr(8'h20, v);
    chk(r, RESP_DECERR);
    axw(8'h20, 32'h0);
    chk(r, RESP_DECERR);
    axw(REG_ADDR, 32'h00001234);
    chk(r, RESP_OKAY);
    axr(REG_ADDR, v);
    chk(v, 32'h00001234);
    for (int k = 0; k < 8; k++) begin
      a = 14'($random(seed)) & 14'h3FF0;
      d = 18'($random(seed));
      ln = 2'(k);
      m = mrg(~d, d, ln);
      cmd(OP_MEM_WR, a, ~d, 2'h3);
      cmd(OP_MEM_WR, a, d, ln);
      cmd(OP_MEM_RD, a, 0, 2'h3);
      chk(v, {14'h0, m});
      cmd(OP_MEM_RD, a, 0, ln);
      chk(v, {14'h0, mrg(~m, m, ln)});
    end
    a = 14'($random(seed)) | 14'h3FF8;
    cmd(OP_TOK_ACQ, a, 0, 0);
    chk(dev_i.own[a[2:0]], 1);
    dev_i.tok(2, a[2:0], 0);
    cmd(OP_TOK_RD, a, 0, 0);
    chk(v, 0);
    cmd(OP_TOK_WR, a, 18'h00001, 0);
    cmd(OP_TOK_RD, a, 0, 0);
    chk(v, 32'h3FFFF);
    go(OP_TOK_ACQ, a, 0, 0);
    repeat (60) @(posedge mclk);
    axw(REG_CTRL, 32'h40);
    fin(v);
    chk(v[ST_OWNED], 0);
    chk(dev_i.req[1][a[2:0]], 0);
    go(OP_TOK_ACQ, a, 0, 0);
    repeat (60) @(posedge mclk);
    dev_i.tok(2, a[2:0], 1);
    fin(v);
    chk(v[ST_OWNED], 1);
    cmd(OP_TOK_WR, a, 18'h00001, 0);
    cmd(OP_TOK_RD, a, 0, 0);
    chk(v, 32'h3FFFF);
    cmd(OP_TOK_WR, a ^ 14'h3FF8, 18'h3FFFE, 0);
    chk(dev_i.own[a[2:0]], 1);
    dev_i.far_mail();
    cmd(OP_MEM_RD, 14'h3FFF, 0, 2'h3);
    axr(REG_STATUS, v);
    chk(v[ST_INT], 1);
    busy_n <= 0;
    cmd(OP_MEM_RD, 14'h3FFE, 0, 2'h3);
    axr(REG_STATUS, v);
    chk(v[ST_INT +: 2], 2'h3);
    busy_n <= 1;
    cmd(OP_MEM_RD, 14'h3FFE, 0, 2'h3);
    axr(REG_STATUS, v);
    chk(v[ST_INT], 0);
    report_and_stop();
  end
endmodule
